// >>> event_stamp_month_year.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "event_stamp_map.svh"

module event_stamp_month_year
    import event_stamp_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              event_input_pin,
    input  wire logic [7:0]        cur_month,
    input  wire logic [7:0]        cur_year,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // word index needs eight bits above the byte lanes
    if (ADDR_W < 10) begin : g_bad_addr
        $error("ADDR_W must be at least 10");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    apb_req_t                   req;            // bundled bus request
    stamp_t                     stamp;          // held stamp pair
    evt_ctrl_t                  ctrl;           // software control
    logic [`STAT_WIDTH-1:0]     status;         // sticky event flags
    logic [`STAT_WIDTH-1:0]     mask;           // interrupt mask
    logic                       stamp_held;     // a stamp is stored
    logic                       clear_req;      // clear pulse from bus
    logic                       evt_pulse;      // event from pin logic
    logic                       por_evt;        // power-on event
    logic                       wr_hit;         // write takes effect
    logic                       rd_hit;         // read takes effect
    logic                       take_stamp;     // capture this cycle
    logic                       drop_stamp;     // event not stored
    logic [`STAT_WIDTH-1:0]     stat_set;       // flags raised now
    logic [`STAT_WIDTH-1:0]     stat_clr;       // flags cleared now
    logic [`STAT_WIDTH-1:0]     next_status;    // status after edge
    logic [31:0]                next_rdata;     // read mux result
    logic                       next_err;       // unmapped access

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // month register image: upper three bits always zero
    function automatic logic [7:0] month_image(input logic [7:0] m);
        month_image = {3'b000, m[`MONTH_FIELD_MSB:0]};
    endfunction

    // known register index
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == `IDX_STAMP_MONTH) || (idx == `IDX_STAMP_YEAR)
                 || (idx == `IDX_EVT_CTRL)    || (idx == `IDX_EVT_STATUS)
                 || (idx == `IDX_EVT_MASK);
    endfunction

    // ----------------------------------------------------------------
    // bus request
    // ----------------------------------------------------------------
    assign req.sel    = psel;
    assign req.enable = penable;
    assign req.write  = pwrite;
    assign req.index  = paddr[9:2];
    assign req.wdata  = pwdata;

    // access phase completes on the edge where pready is high
    assign wr_hit = req.sel & req.enable & pready & req.write;
    assign rd_hit = req.sel & req.enable & pready & ~req.write;

    // ----------------------------------------------------------------
    // pin detector
    // ----------------------------------------------------------------
    event_pin_detect u_detect (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .event_input_pin (event_input_pin),
        .event_level_sel (ctrl.level_sel),
        .evt_pulse       (evt_pulse),
        .por_evt         (por_evt)
    );

    // ----------------------------------------------------------------
    // apb handshake
    // ----------------------------------------------------------------
    // pready rises one cycle into the access phase, drops after it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= req.sel & req.enable & ~pready;
        end
    end

    // read mux, evaluated in the access phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (!is_mapped(req.index)) begin
            next_err = 1'b1;
        end else if (req.write) begin
            next_rdata = 32'h0000_0000;
        end else if (req.index == `IDX_STAMP_MONTH) begin
            next_rdata[7:0] = month_image(stamp.month);
        end else if (req.index == `IDX_STAMP_YEAR) begin
            next_rdata[7:0] = stamp.year;
        end else if (req.index == `IDX_EVT_CTRL) begin
            next_rdata[`CTRL_OVERWRITE_BIT] = ctrl.overwrite_sel;
            next_rdata[`CTRL_LEVEL_BIT]     = ctrl.level_sel;
        end else if (req.index == `IDX_EVT_STATUS) begin
            next_rdata[`STAT_WIDTH-1:0] = status;
        end else begin
            next_rdata[`STAT_WIDTH-1:0] = mask;
        end
    end

    // data and error stand with pready
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (req.sel & req.enable & ~pready) begin
            prdata  <= next_rdata;
            pslverr <= next_err;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // stamp registers are read only; writes to them do nothing
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl.overwrite_sel <= 1'b0;
            ctrl.level_sel     <= 1'b0;
        end else if (wr_hit && req.index == `IDX_EVT_CTRL) begin
            ctrl.overwrite_sel <= req.wdata[`CTRL_OVERWRITE_BIT];
            ctrl.level_sel     <= req.wdata[`CTRL_LEVEL_BIT];
        end
    end

    // clear is a write-one command, never stored
    assign clear_req = wr_hit && (req.index == `IDX_EVT_CTRL)
                    && req.wdata[`CTRL_CLEAR_BIT];

    // mask register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mask <= `STAT_WIDTH'(0);
        end else if (wr_hit && req.index == `IDX_EVT_MASK) begin
            mask <= req.wdata[`STAT_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // stamp capture
    // ----------------------------------------------------------------
    // first mode stores only into an empty stamp or one cleared in the same cycle; last mode always
    assign take_stamp = evt_pulse & (ctrl.overwrite_sel | ~stamp_held
                                     | clear_req);
    assign drop_stamp = evt_pulse & ~take_stamp;

    // capture wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stamp.month <= `STAMP_RESET;
            stamp.year  <= `STAMP_RESET;
            stamp_held  <= 1'b0;
        end else if (por_evt) begin
            stamp.month <= `MONTH_POR_STAMP;
            stamp.year  <= `YEAR_POR_STAMP;
            stamp_held  <= 1'b1;
        end else if (take_stamp) begin
            stamp.month <= month_image(cur_month);
            stamp.year  <= cur_year;
            stamp_held  <= 1'b1;
        end else if (clear_req) begin
            stamp.month <= `STAMP_RESET;
            stamp.year  <= `STAMP_RESET;
            stamp_held  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    // raise on stored or refused events, write one to clear
    always_comb begin
        stat_set = `STAT_WIDTH'(0);
        stat_clr = `STAT_WIDTH'(0);
        stat_set[`STAT_EVENT_BIT]   = take_stamp | por_evt;
        stat_set[`STAT_DROPPED_BIT] = drop_stamp & ~por_evt;
        if (wr_hit && req.index == `IDX_EVT_STATUS) begin
            stat_clr = req.wdata[`STAT_WIDTH-1:0];
        end
        next_status = (status & ~stat_clr) | stat_set;
    end

    // sticky flags, set beats clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status <= `STAT_WIDTH'(0);
        end else begin
            status <= next_status;
        end
    end

    // registered level interrupt from the next flag values
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & mask);
        end
    end

endmodule

// >>> event_stamp_map.svh
`ifndef EVENT_STAMP_MAP_SVH
`define EVENT_STAMP_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_STAMP_MONTH    8'h2C
`define IDX_STAMP_YEAR     8'h2D
`define IDX_EVT_CTRL       8'h30
`define IDX_EVT_STATUS     8'h31
`define IDX_EVT_MASK       8'h32

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_OVERWRITE_BIT 0
`define CTRL_LEVEL_BIT     1
`define CTRL_CLEAR_BIT     2
`define STAT_EVENT_BIT     0
`define STAT_DROPPED_BIT   1
`define STAT_WIDTH         2
`define MONTH_FIELD_MSB    4

// ----------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------
`define STAMP_RESET        8'h00
`define MONTH_POR_STAMP    8'h01
`define YEAR_POR_STAMP     8'h00
`define POR_WINDOW_CYCLES  3'h4

`endif

// >>> event_stamp_pkg.sv
package event_stamp_pkg;

    // captured calendar pair
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] year;
    } stamp_t;

    // software control bits
    typedef struct packed {
        logic overwrite_sel;
        logic level_sel;
    } evt_ctrl_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  index;
        logic [31:0] wdata;
    } apb_req_t;

endpackage

// >>> event_pin_detect.sv
`timescale 1ns/1ps
`include "event_stamp_map.svh"

module event_pin_detect (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic event_input_pin,
    input  wire logic event_level_sel,
    output logic      evt_pulse,
    output logic      por_evt
);

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic       sync_a;      // first stage, read only by sync_b
    logic       sync_b;      // safe pin level
    logic       prev_active; // active level one cycle ago
    logic [2:0] por_count;   // cycles since reset release
    logic       active;      // pin at the selected event level

    // two flops, idle high so a low pin after reset is seen as new
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= event_input_pin;
            sync_b <= sync_a;
        end
    end

    // low level counts when level select is zero
    assign active = event_level_sel ? sync_b : ~sync_b;

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    // one pulse per entry into the active level
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prev_active <= 1'b0;
        end else begin
            prev_active <= active;
        end
    end

    assign evt_pulse = active & ~prev_active;

    // window right after reset in which an event is the power-on one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            por_count <= 3'h0;
        end else if (por_count != `POR_WINDOW_CYCLES) begin
            por_count <= por_count + 3'h1;
        end
    end

    assign por_evt = evt_pulse & (por_count != `POR_WINDOW_CYCLES);

endmodule

// >>> event_stamp_month_year_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// checker on the top ports
// ----------------------------------------
module event_stamp_month_year_asserts #(
    parameter int ADDR_W = 10
) (
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq
);
    wire logic [7:0] idx    = paddr[9:2];        // register index
    wire logic       rd_end = pready && !pwrite; // read answer cycle

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_delay_a: assert property (psel && !penable |-> !pready ##2 pready)
        else $error("pready not in second access cycle");
    idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside answer cycle");
    month_zero_a: assert property (rd_end && idx == 8'h2C |-> prdata[31:5] == 27'h0)
        else $error("month upper bits not zero");
    month_range_a: assert property (rd_end && idx == 8'h2C |->
        prdata[4:0] inside {[5'h00:5'h09], [5'h10:5'h12]})
        else $error("month out of range");
    year_bcd_a: assert property (rd_end && idx == 8'h2D |-> prdata[31:8] == 24'h0 &&
        prdata[7:4] <= 4'h9 && prdata[3:0] <= 4'h9)
        else $error("year not two bcd digits");
    map_err_a: assert property (pready |->
        pslverr == !(idx inside {8'h2C, 8'h2D, 8'h30, 8'h31, 8'h32}))
        else $error("error response wrong for index");
    reset_quiet_a: assert property ($rose(resetn) |-> !irq && !pready ##1 !pready)
        else $error("outputs active right after reset");

    cover property (rd_end && idx == 8'h2C && prdata[4:0] != 5'h0);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule

bind event_stamp_month_year event_stamp_month_year_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// >>> apb_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host processor driving the register bus
// ----------------------------------------
module apb_host_model (
    input  wire logic  ref_clk,
    input  wire logic  pready,
    output logic       psel,
    output logic       penable,
    output logic       pwrite,
    output logic [9:0] paddr,
    output logic [31:0] pwdata
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
    end

    // one transfer: setup, access, wait for pready
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // pready ends this wait; if it never comes, only the bench watchdog does
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data no longer valid
    endtask
endmodule

// >>> event_stamp_month_year_tb.sv
`timescale 1ns/1ps
`include "event_stamp_map.svh"
module event_stamp_month_year_tb;
    typedef struct packed {logic rd; logic err; logic [31:0] data;} note_t;
    logic        ref_clk, resetn, event_input_pin, psel, penable, pwrite;
    logic        pready, pslverr, irq;
    logic [7:0]  cur_month, cur_year, m, y;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, seed;
    int          errors, checks_done;
    note_t       notes[$]; // expected answers, oldest first

    event_stamp_month_year #(.ADDR_W(10)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .event_input_pin(event_input_pin), .cur_month(cur_month), .cur_year(cur_year),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    apb_host_model u_host (.ref_clk(ref_clk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] bcd(input int v);
        return 8'(((v / 10) << 4) | (v % 10));
    endfunction
    task automatic fail(input string s);
        errors++;
        $display("[FAIL] %0t %s", $time, s);
    endtask
    task automatic cmp_answer(input note_t n);
        checks_done++;
        if ((n.rd && prdata !== n.data) || pslverr !== n.err) fail("bus answer");
    endtask
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge ref_clk);
        checks_done++;
        if (irq !== e) fail("irq level");
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic e = 1'b0);
        notes.push_back({1'b1, e, d});
        u_host.xfer(1'b0, i, 32'h0);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        notes.push_back({1'b0, 1'b0, 32'h0});
        u_host.xfer(1'b1, i, d);
    endtask
    // pin pulse into the active low level with given counters
    task automatic evt(input logic [7:0] mo, input logic [7:0] yr);
        @(posedge ref_clk);
        cur_month <= mo;
        cur_year <= yr;
        event_input_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        event_input_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) fail("unexpected answer");
            else cmp_answer(notes.pop_front());
        end
    end
    initial begin
        #100000;
        fail("timeout");
        report_and_stop;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        checks_done = 0;
        seed = 32'd35789;
        resetn = 1'b0;
        event_input_pin = 1'b0; // low pin at power-on
        cur_month = 8'h01;
        cur_year = 8'h00;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        event_input_pin <= 1'b1;
        rd(`IDX_STAMP_MONTH, 32'h01);
        rd(`IDX_STAMP_YEAR, 32'h00);
        wr(`IDX_STAMP_MONTH, 32'hFF);
        rd(`IDX_STAMP_MONTH, 32'h01);
        $display("done: power-on stamp");
        wr(`IDX_EVT_CTRL, 32'h4);
        rd(`IDX_STAMP_MONTH, 32'h00);
        rd(`IDX_STAMP_YEAR, 32'h00);
        $display("done: clear");
        evt(8'h12, 8'h99);
        rd(`IDX_STAMP_MONTH, 32'h12);
        rd(`IDX_STAMP_YEAR, 32'h99);
        evt(8'h05, 8'h23);
        rd(`IDX_STAMP_MONTH, 32'h12);
        rd(`IDX_STAMP_YEAR, 32'h99);
        rd(`IDX_EVT_STATUS, 32'h3);
        chk_irq(1'b0);
        wr(`IDX_EVT_MASK, 32'h1);
        chk_irq(1'b1);
        wr(`IDX_EVT_STATUS, 32'h3);
        chk_irq(1'b0);
        $display("done: keep first, interrupt");
        wr(`IDX_EVT_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            m = bcd(int'(xs() % 12) + 1);
            y = bcd(int'(xs() % 100));
            evt(m | {3'(xs()), 5'h00}, y);
            rd(`IDX_STAMP_MONTH, {24'h0, m});
            rd(`IDX_STAMP_YEAR, {24'h0, y});
        end
        chk_irq(1'b1);
        // high level select with the pin already high is itself an event
        wr(`IDX_EVT_CTRL, 32'h3);
        rd(`IDX_EVT_CTRL, 32'h3);
        rd(`IDX_STAMP_MONTH, {24'h0, m});
        rd(`IDX_STAMP_YEAR, {24'h0, y});
        $display("done: keep last");
        // second reset with the pin high: no power-on stamp
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(`IDX_STAMP_MONTH, 32'h00);
        rd(`IDX_EVT_STATUS, 32'h0);
        chk_irq(1'b0);
        $display("done: reset with pin high");
        rd(8'h00, 32'h0, 1'b1);
        $display("done: unmapped");
        report_and_stop;
    end
endmodule
